// *** verilog/tcx_pkg.sv ***
package tcx_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_CONTROL_FLAGS = 8'h88;
    localparam logic [7:0] IDX_MODE_SELECT = 8'h89;
    localparam logic [7:0] IDX_T0_LOW = 8'h8a;
    localparam logic [7:0] IDX_T1_LOW = 8'h8b;
    localparam logic [7:0] IDX_T0_HIGH = 8'h8c;
    localparam logic [7:0] IDX_T1_HIGH = 8'h8d;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
    localparam logic [7:0] IDX_VECTOR_ACK = 8'h92;

    // Reset values
    localparam logic [7:0] RST_CONTROL_FLAGS = 8'h00;
    localparam logic [7:0] RST_MODE_SELECT = 8'h00;
    localparam logic [7:0] RST_T0_LOW = 8'h00;
    localparam logic [7:0] RST_T1_LOW = 8'h00;
    localparam logic [7:0] RST_T0_HIGH = 8'h00;
    localparam logic [7:0] RST_T1_HIGH = 8'h00;
    localparam logic [3:0] RST_IRQ_STATUS = 4'h0;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;

    // Control and flags register bit positions
    localparam int BIT_T1_OVF = 7;
    localparam int BIT_T1_RUN = 6;
    localparam int BIT_T0_OVF = 5;
    localparam int BIT_T0_RUN = 4;
    localparam int BIT_X1_FLAG = 3;
    localparam int BIT_X1_TYPE = 2;
    localparam int BIT_X0_FLAG = 1;
    localparam int BIT_X0_TYPE = 0;

    // Mode select: one nibble per timer, same layout in each
    localparam int NIB_T0 = 0;
    localparam int NIB_T1 = 4;
    localparam int FLD_MODE_LSB = 0;
    localparam int FLD_SOURCE = 2;
    localparam int FLD_GATING = 3;

    // Event positions in status, mask, acknowledge and request vectors
    localparam int EV_T0_OVF = 0;
    localparam int EV_X0 = 1;
    localparam int EV_T1_OVF = 2;
    localparam int EV_X1 = 3;
    localparam int NUM_EV = 4;

    // Pin positions in the conditioned pin vector
    localparam int PIN_X0 = 0;
    localparam int PIN_X1 = 1;
    localparam int PIN_C0 = 2;
    localparam int PIN_C1 = 3;
    localparam int NUM_PINS = 4;

    // Timer mode counts once per this many clock cycles
    localparam int TIMER_TICK_CYCLES = 2;

    typedef enum logic [1:0] {
        TCX_MODE_13BIT,
        TCX_MODE_16BIT,
        TCX_MODE_RELOAD,
        TCX_MODE_SPLIT
    } tcx_mode_t;

    // Count permission from run bit, gating bit and pin level
    function automatic logic tcx_enable(input logic run, input logic gating, input logic pin_high);
        tcx_enable = run & (~gating | pin_high);
    endfunction

endpackage

// *** verilog/tcx_pin_if.sv ***
`timescale 1ns/1ps
interface tcx_pin_if;
    logic [3:0] level;
    logic [3:0] fall;
    modport src (output level, output fall);
    modport dst (input level, input fall);
endinterface

// *** verilog/tcx_pin_sync.sv ***
`timescale 1ns/1ps
module tcx_pin_sync import tcx_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NUM_PINS-1:0] raw,
    tcx_pin_if.src pins
);
    typedef struct packed {
        logic [NUM_PINS-1:0] s1;
        logic [NUM_PINS-1:0] s2;
        logic [NUM_PINS-1:0] s3;
    } tcx_sync_t;

    tcx_sync_t r;
    tcx_sync_t next_r;

    // Two stages against metastability, third only for edge compare
    always_comb begin
        next_r.s1 = raw;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    // Reset high: pins idle high, so no false fall after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign pins.level = r.s2;
    assign pins.fall = r.s3 & ~r.s2;
endmodule

// *** verilog/tcx_count_unit.sv ***
`timescale 1ns/1ps
module tcx_count_unit import tcx_pkg::*; (
    input wire tcx_mode_t mode,
    input wire logic tick,
    input wire logic [7:0] low,
    input wire logic [7:0] high,
    output logic [7:0] next_low,
    output logic [7:0] next_high,
    output logic ovf
);
    logic [13:0] sum13;
    logic [16:0] sum16;
    logic [8:0] sum8;

    // Candidate sums for each width
    assign sum13 = {1'b0, high, low[4:0]} + 14'h0001;
    assign sum16 = {1'b0, high, low} + 17'h00001;
    assign sum8 = {1'b0, low} + 9'h001;

    // Step the pair by one tick in the chosen mode
    always_comb begin
        next_low = low;
        next_high = high;
        ovf = 1'b0;
        if (tick) begin
            case (mode)
                TCX_MODE_13BIT: begin
                    next_high = sum13[12:5];
                    next_low = {low[7:5], sum13[4:0]};
                    ovf = sum13[13];
                end
                TCX_MODE_16BIT: begin
                    next_high = sum16[15:8];
                    next_low = sum16[7:0];
                    ovf = sum16[16];
                end
                TCX_MODE_RELOAD: begin
                    next_low = sum8[8] ? high : sum8[7:0];
                    ovf = sum8[8];
                end
                TCX_MODE_SPLIT: begin
                    next_low = sum8[7:0];
                    ovf = sum8[8];
                end
                default: begin
                    next_low = low;
                end
            endcase
        end
    end
endmodule

// *** verilog/tcx_timer_pair.sv ***
// Our own choice: the APB slave port.
`timescale 1ns/1ps
// What this block does
// - A timer overflow raises its overflow flag, which is cleared when the CPU vectors to its handler.
// - A timer's run bit lets it advance when one and freezes its count when zero.
// - A falling edge on an external interrupt pin sets its edge flag, cleared on vectoring.
// - The trigger-type bit picks level requests while the pin is low (0) or falling-edge requests (1).
// - With gating clear a timer counts whenever run is set; with gating set only while its pin is high too.
// - With count source at zero the timer steps once every two clock cycles.
// - With count source at one the timer steps on each falling edge of its counter pin.
// - Mode 00 runs an 8-bit counter in the high byte fed by a 5-bit prescaler in the low byte.
// - Mode 01 runs one 16-bit counter from the high and low bytes.
// - Mode 10 counts the low byte and reloads it from the high byte on each overflow.
// - Mode 11 stops timer one; timer zero then splits into two 8-bit counters, the high one using timer one's run and flag.
module tcx_timer_pair import tcx_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    input wire logic counter_input_pin_zero,
    input wire logic counter_input_pin_one,
    output logic [NUM_EV-1:0] int_request,
    output logic irq
);
    typedef struct packed {
        logic [7:0] timer_control_flags;
        logic [7:0] timer_mode_select;
        logic [7:0] timer_zero_low_byte;
        logic [7:0] timer_one_low_byte;
        logic [7:0] timer_zero_high_byte;
        logic [7:0] timer_one_high_byte;
        logic [NUM_EV-1:0] irq_status;
        logic [NUM_EV-1:0] irq_mask;
        logic div_phase;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [NUM_EV-1:0] int_request;
        logic irq;
    } tcx_state_t;

    tcx_state_t r;
    tcx_state_t next_r;

    tcx_pin_if pins ();

    tcx_mode_t mode0;
    tcx_mode_t mode1;
    logic tick0;
    logic tick1;
    logic tick_split_high;
    logic [7:0] cu0_low;
    logic [7:0] cu0_high;
    logic cu0_ovf;
    logic [7:0] cu1_low;
    logic [7:0] cu1_high;
    logic cu1_ovf;
    logic [8:0] split_sum;
    logic split_ovf;
    logic t1_ovf_event;
    logic x0_edge;
    logic x1_edge;
    logic setup_phase;
    logic write_done;
    logic access_done;
    logic [7:0] wbyte;

    // Full word address match at index times four
    function automatic logic tcx_hit(input logic [11:0] addr, input logic [7:0] idx);
        tcx_hit = (addr == {2'b00, idx, 2'b00});
    endfunction

    function automatic logic tcx_mapped(input logic [11:0] addr);
        tcx_mapped = tcx_hit(addr, IDX_CONTROL_FLAGS) | tcx_hit(addr, IDX_MODE_SELECT)
            | tcx_hit(addr, IDX_T0_LOW) | tcx_hit(addr, IDX_T1_LOW)
            | tcx_hit(addr, IDX_T0_HIGH) | tcx_hit(addr, IDX_T1_HIGH)
            | tcx_hit(addr, IDX_IRQ_STATUS) | tcx_hit(addr, IDX_IRQ_MASK)
            | tcx_hit(addr, IDX_VECTOR_ACK);
    endfunction

    tcx_pin_sync u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .raw({counter_input_pin_one, counter_input_pin_zero, ext_irq_pin_one, ext_irq_pin_zero}),
        .pins(pins.src)
    );

    assign mode0 = tcx_mode_t'(r.timer_mode_select[NIB_T0 + FLD_MODE_LSB +: 2]);
    assign mode1 = tcx_mode_t'(r.timer_mode_select[NIB_T1 + FLD_MODE_LSB +: 2]);

    // Tick selection: divided clock or counter pin edge, gated by run and pin
    always_comb begin
        tick0 = tcx_enable(r.timer_control_flags[BIT_T0_RUN],
            r.timer_mode_select[NIB_T0 + FLD_GATING], pins.level[PIN_X0])
            & (r.timer_mode_select[NIB_T0 + FLD_SOURCE] ? pins.fall[PIN_C0]
            : r.div_phase);
        tick1 = tcx_enable(r.timer_control_flags[BIT_T1_RUN],
            r.timer_mode_select[NIB_T1 + FLD_GATING], pins.level[PIN_X1])
            & (r.timer_mode_select[NIB_T1 + FLD_SOURCE] ? pins.fall[PIN_C1]
            : r.div_phase)
            & (mode1 != TCX_MODE_SPLIT);
        // Split high byte is a plain timer borrowing timer one's run bit
        tick_split_high = (mode0 == TCX_MODE_SPLIT) & r.timer_control_flags[BIT_T1_RUN] & r.div_phase;
    end

    tcx_count_unit u_count_zero (
        .mode(mode0),
        .tick(tick0),
        .low(r.timer_zero_low_byte),
        .high(r.timer_zero_high_byte),
        .next_low(cu0_low),
        .next_high(cu0_high),
        .ovf(cu0_ovf)
    );

    tcx_count_unit u_count_one (
        .mode(mode1),
        .tick(tick1),
        .low(r.timer_one_low_byte),
        .high(r.timer_one_high_byte),
        .next_low(cu1_low),
        .next_high(cu1_high),
        .ovf(cu1_ovf)
    );

    assign split_sum = {1'b0, r.timer_zero_high_byte} + 9'h001;
    assign split_ovf = tick_split_high & split_sum[8];
    // Timer one's flag answers to the split high byte in that mode
    assign t1_ovf_event = cu1_ovf | split_ovf;

    // Edge requests count only in edge trigger mode
    assign x0_edge = pins.fall[PIN_X0] & r.timer_control_flags[BIT_X0_TYPE];
    assign x1_edge = pins.fall[PIN_X1] & r.timer_control_flags[BIT_X1_TYPE];

    // Bus phases: answer data prepared in setup, so access ends in one cycle
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & r.pready;
    assign write_done = access_done & pwrite & ~r.pslverr;
    assign wbyte = pwdata[7:0];

    // Next state: counting, then software writes, then hardware flag sets
    always_comb begin
        next_r = r;
        next_r.div_phase = ~r.div_phase;

        // Counting
        next_r.timer_zero_low_byte = cu0_low;
        next_r.timer_zero_high_byte = (mode0 == TCX_MODE_SPLIT) ? (tick_split_high ? split_sum[7:0]
            : r.timer_zero_high_byte) : cu0_high;
        next_r.timer_one_low_byte = cu1_low;
        next_r.timer_one_high_byte = cu1_high;

        // Register writes; a write beats a tick in the same cycle
        if (write_done) begin
            if (tcx_hit(paddr, IDX_CONTROL_FLAGS)) begin
                next_r.timer_control_flags = wbyte;
            end
            if (tcx_hit(paddr, IDX_MODE_SELECT)) begin
                next_r.timer_mode_select = wbyte;
            end
            if (tcx_hit(paddr, IDX_T0_LOW)) begin
                next_r.timer_zero_low_byte = wbyte;
            end
            if (tcx_hit(paddr, IDX_T1_LOW)) begin
                next_r.timer_one_low_byte = wbyte;
            end
            if (tcx_hit(paddr, IDX_T0_HIGH)) begin
                next_r.timer_zero_high_byte = wbyte;
            end
            if (tcx_hit(paddr, IDX_T1_HIGH)) begin
                next_r.timer_one_high_byte = wbyte;
            end
            if (tcx_hit(paddr, IDX_IRQ_STATUS)) begin
                next_r.irq_status = r.irq_status & ~wbyte[NUM_EV-1:0];
            end
            if (tcx_hit(paddr, IDX_IRQ_MASK)) begin
                next_r.irq_mask = wbyte[NUM_EV-1:0];
            end
            // Acknowledge stands for the CPU vectoring to each handler
            if (tcx_hit(paddr, IDX_VECTOR_ACK)) begin
                if (wbyte[EV_T0_OVF]) begin
                    next_r.timer_control_flags[BIT_T0_OVF] = 1'b0;
                end
                if (wbyte[EV_T1_OVF]) begin
                    next_r.timer_control_flags[BIT_T1_OVF] = 1'b0;
                end
                if (wbyte[EV_X0] & r.timer_control_flags[BIT_X0_TYPE]) begin
                    next_r.timer_control_flags[BIT_X0_FLAG] = 1'b0;
                end
                if (wbyte[EV_X1] & r.timer_control_flags[BIT_X1_TYPE]) begin
                    next_r.timer_control_flags[BIT_X1_FLAG] = 1'b0;
                end
            end
        end

        // Hardware sets win over any clear in the same cycle
        if (cu0_ovf) begin
            next_r.timer_control_flags[BIT_T0_OVF] = 1'b1;
        end
        if (t1_ovf_event) begin
            next_r.timer_control_flags[BIT_T1_OVF] = 1'b1;
        end
        if (x0_edge) begin
            next_r.timer_control_flags[BIT_X0_FLAG] = 1'b1;
        end
        if (x1_edge) begin
            next_r.timer_control_flags[BIT_X1_FLAG] = 1'b1;
        end
        // Level mode: flag follows the low pin, no latching
        if (!r.timer_control_flags[BIT_X0_TYPE]) begin
            next_r.timer_control_flags[BIT_X0_FLAG] = ~pins.level[PIN_X0];
        end
        if (!r.timer_control_flags[BIT_X1_TYPE]) begin
            next_r.timer_control_flags[BIT_X1_FLAG] = ~pins.level[PIN_X1];
        end

        // Sticky status, write one to clear, set wins
        next_r.irq_status[EV_T0_OVF] = next_r.irq_status[EV_T0_OVF] | cu0_ovf;
        next_r.irq_status[EV_T1_OVF] = next_r.irq_status[EV_T1_OVF] | t1_ovf_event;
        next_r.irq_status[EV_X0] = next_r.irq_status[EV_X0] | x0_edge
            | (~r.timer_control_flags[BIT_X0_TYPE] & pins.fall[PIN_X0]);
        next_r.irq_status[EV_X1] = next_r.irq_status[EV_X1] | x1_edge
            | (~r.timer_control_flags[BIT_X1_TYPE] & pins.fall[PIN_X1]);
        next_r.irq = |(next_r.irq_status & next_r.irq_mask);

        // Request lines toward the CPU interrupt logic
        next_r.int_request[EV_T0_OVF] = next_r.timer_control_flags[BIT_T0_OVF];
        next_r.int_request[EV_T1_OVF] = next_r.timer_control_flags[BIT_T1_OVF];
        next_r.int_request[EV_X0] = next_r.timer_control_flags[BIT_X0_FLAG];
        next_r.int_request[EV_X1] = next_r.timer_control_flags[BIT_X1_FLAG];

        // Bus answer: data and error captured at setup, ready for access
        if (setup_phase) begin
            next_r.pready = 1'b1;
            next_r.pslverr = ~tcx_mapped(paddr);
            next_r.prdata = 32'h0000_0000;
            if (tcx_hit(paddr, IDX_CONTROL_FLAGS)) begin
                next_r.prdata[7:0] = r.timer_control_flags;
            end
            if (tcx_hit(paddr, IDX_MODE_SELECT)) begin
                next_r.prdata[7:0] = r.timer_mode_select;
            end
            if (tcx_hit(paddr, IDX_T0_LOW)) begin
                next_r.prdata[7:0] = r.timer_zero_low_byte;
            end
            if (tcx_hit(paddr, IDX_T1_LOW)) begin
                next_r.prdata[7:0] = r.timer_one_low_byte;
            end
            if (tcx_hit(paddr, IDX_T0_HIGH)) begin
                next_r.prdata[7:0] = r.timer_zero_high_byte;
            end
            if (tcx_hit(paddr, IDX_T1_HIGH)) begin
                next_r.prdata[7:0] = r.timer_one_high_byte;
            end
            if (tcx_hit(paddr, IDX_IRQ_STATUS)) begin
                next_r.prdata[NUM_EV-1:0] = r.irq_status;
            end
            if (tcx_hit(paddr, IDX_IRQ_MASK)) begin
                next_r.prdata[NUM_EV-1:0] = r.irq_mask;
            end
        end else if (access_done) begin
            next_r.pready = 1'b0;
            next_r.pslverr = 1'b0;
        end
    end

    // All state in one register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.timer_control_flags <= RST_CONTROL_FLAGS;
            r.timer_mode_select <= RST_MODE_SELECT;
            r.timer_zero_low_byte <= RST_T0_LOW;
            r.timer_one_low_byte <= RST_T1_LOW;
            r.timer_zero_high_byte <= RST_T0_HIGH;
            r.timer_one_high_byte <= RST_T1_HIGH;
            r.irq_status <= RST_IRQ_STATUS;
            r.irq_mask <= RST_IRQ_MASK;
            r.div_phase <= 1'b0;
            r.prdata <= 32'h0000_0000;
            r.pready <= 1'b0;
            r.pslverr <= 1'b0;
            r.int_request <= 4'h0;
            r.irq <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign int_request = r.int_request;
    assign irq = r.irq;
endmodule

// *** tb/tcx_timer_pair_sva.sv ***
`timescale 1ns/1ps
module tcx_sva import tcx_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_irq_pin_zero,
    input wire logic [NUM_EV-1:0] int_request,
    input wire logic irq
);
    logic [7:0] ctl;
    logic [3:0] msk;
    logic wr;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Completed write, as the slave takes it
    assign wr = psel & penable & pready & pwrite;

    // Software-owned control and mask bits, mirrored from bus writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 8'h00;
            msk <= 4'h0;
        end else if (wr && paddr == {2'b00, IDX_CONTROL_FLAGS, 2'b00}) begin
            ctl <= pwdata[7:0];
        end else if (wr && paddr == {2'b00, IDX_IRQ_MASK, 2'b00}) begin
            msk <= pwdata[3:0];
        end
    end

    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("no ready after setup");
    property p_ready_single;
        pready |=> !pready;
    endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("ready held too long");
    property p_err_unmapped;
        psel && !penable && paddr == 12'h0fc |=> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("unmapped access not refused");
    property p_err_read_zero;
        pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    a_err_read_zero: assert property (p_err_read_zero)
        else $error("refused read returns data");
    property p_level_low;
        (!ctl[BIT_X0_TYPE] && !ext_irq_pin_zero) [*5] |-> int_request[EV_X0];
    endproperty
    a_level_low: assert property (p_level_low)
        else $error("level request missing");
    property p_level_high;
        (!ctl[BIT_X0_TYPE] && ext_irq_pin_zero) [*5] |-> !int_request[EV_X0];
    endproperty
    a_level_high: assert property (p_level_high)
        else $error("level request while pin high");
    property p_edge_set;
        ctl[BIT_X0_TYPE] && $fell(ext_irq_pin_zero) |-> ##[2:5] int_request[EV_X0];
    endproperty
    a_edge_set: assert property (p_edge_set)
        else $error("edge flag not set");
    property p_t0_frozen;
        (!ctl[BIT_T0_RUN]) [*3] |-> !$rose(int_request[EV_T0_OVF]);
    endproperty
    a_t0_frozen: assert property (p_t0_frozen)
        else $error("stopped timer zero overflowed");
    property p_t1_frozen;
        (!ctl[BIT_T1_RUN]) [*3] |-> !$rose(int_request[EV_T1_OVF]);
    endproperty
    a_t1_frozen: assert property (p_t1_frozen)
        else $error("stopped timer one overflowed");
    property p_irq_masked;
        msk == 4'h0 |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("irq with all masked");
    property p_irq_raise;
        $rose(int_request[EV_T0_OVF]) && msk[EV_T0_OVF] |-> irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("irq missing on overflow");
endmodule

bind tcx_timer_pair tcx_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin_zero(ext_irq_pin_zero), .int_request(int_request), .irq(irq));

// *** tb/tcx_pin_model.sv ***
`timescale 1ns/1ps
module tcx_pin_model (
    input wire logic pclk,
    output logic [3:0] pins
);
    // Pins idle high so no false fall at start
    initial pins = 4'hf;

    // Low for n clocks, then high for n clocks
    task automatic pulse(input int k, input int n);
        @(posedge pclk);
        pins[k] <= 1'b0;
        repeat (n) @(posedge pclk);
        pins[k] <= 1'b1;
        repeat (n) @(posedge pclk);
    endtask

    // Park one pin at a level
    task automatic hold(input int k, input logic v);
        @(posedge pclk);
        pins[k] <= v;
    endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb import tcx_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pins, int_request;
    logic [33:0] exq[$];
    logic [33:0] mon_e;
    logic [7:0] rs;
    int num_errors, compares;

    tcx_timer_pair dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_pin_zero(pins[PIN_X0]), .ext_irq_pin_one(pins[PIN_X1]),
        .counter_input_pin_zero(pins[PIN_C0]), .counter_input_pin_one(pins[PIN_C1]),
        .int_request(int_request), .irq(irq));
    tcx_pin_model pin_u (.pclk(pclk), .pins(pins));

    always #2.5 pclk = ~pclk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    task automatic stop_test();
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // One bus transfer; its expected answer goes on the queue first
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
                        input logic er, input logic c);
        exq.push_back({c, er, e});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        xfer(1'b1, {2'b00, i, 2'b00}, {24'h0, d}, 32'h0, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        xfer(1'b0, {2'b00, i, 2'b00}, 32'h0, {24'h0, e}, 1'b0, 1'b1);
    endtask

    // Bounded wait for a request bit, then check the elapsed clocks
    task automatic wait_ev(input int b, input int lo, input int hi, input string m);
        int c;
        c = 0;
        while (int_request[b] !== 1'b1 && c < 3000) begin
            @(posedge pclk);
            c++;
        end
        chk(c >= lo && c <= hi, m);
    endtask

    // Load a timer, start it, time its overflow; t ticks of two clocks
    task automatic tcase(input logic [7:0] mode, input logic [7:0] li, input logic [7:0] lv,
                         input logic [7:0] hi, input logic [7:0] hv, input logic [7:0] run,
                         input int b, input int t, input string m);
        wr(IDX_CONTROL_FLAGS, 8'h00);
        wr(IDX_MODE_SELECT, mode);
        wr(li, lv);
        wr(hi, hv);
        wr(IDX_CONTROL_FLAGS, run);
        wait_ev(b, 2 * t - 2, 2 * t + 3, m);
    endtask

    // Compare every completed transfer with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exq.size() == 0) chk(1'b0, "unexpected ready");
            else begin
                mon_e = exq.pop_front();
                chk(pslverr === mon_e[32], "error response");
                if (mon_e[33]) chk(prdata === mon_e[31:0], "read data");
            end
        end
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        stop_test();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h0;
        rs = 8'h49;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(int_request === 4'h0 && irq === 1'b0, "outputs after reset");
        for (int i = 0; i < 6; i++) rd(8'(IDX_CONTROL_FLAGS + i), 8'h00);
        rd(IDX_IRQ_STATUS, 8'h00);
        rd(IDX_IRQ_MASK, 8'h00);
        // Random bytes survive 20 clocks while stopped
        for (int i = 0; i < 5; i++) begin
            rs = lfsr(rs);
            wr(8'(IDX_MODE_SELECT + i), rs);
            repeat (20) @(posedge pclk);
            rd(8'(IDX_MODE_SELECT + i), rs);
        end
        xfer(1'b1, 12'h0fc, 32'h5a, 32'h0, 1'b1, 1'b0);
        xfer(1'b0, 12'h0fc, 32'h0, 32'h0, 1'b1, 1'b1);
        // Timer modes by overflow timing
        wr(IDX_IRQ_MASK, 8'h01);
        tcase(8'h01, IDX_T0_LOW, 8'hf0, IDX_T0_HIGH, 8'hff, 8'h10, EV_T0_OVF, 16, "16-bit");
        @(posedge pclk);
        chk(irq === 1'b1, "irq after overflow");
        wr(IDX_CONTROL_FLAGS, 8'h20);
        rd(IDX_CONTROL_FLAGS, 8'h20);
        wr(IDX_VECTOR_ACK, 8'h01);
        @(posedge pclk);
        chk(int_request[EV_T0_OVF] === 1'b0, "flag kept after vectoring");
        wr(IDX_IRQ_STATUS, 8'h01);
        @(posedge pclk);
        chk(irq === 1'b0, "irq after status clear");
        wr(IDX_IRQ_MASK, 8'h00);
        tcase(8'h00, IDX_T0_LOW, 8'h1e, IDX_T0_HIGH, 8'hff, 8'h10, EV_T0_OVF, 2, "13-bit");
        tcase(8'h20, IDX_T1_LOW, 8'hfd, IDX_T1_HIGH, 8'hfe, 8'h40, EV_T1_OVF, 3, "reload");
        wr(IDX_VECTOR_ACK, 8'h04);
        wait_ev(EV_T1_OVF, 0, 6, "no reload");
        tcase(8'h33, IDX_T0_LOW, 8'hfc, IDX_T0_HIGH, 8'hfa, 8'h10, EV_T0_OVF, 4, "split low");
        wr(IDX_CONTROL_FLAGS, 8'h50);
        wait_ev(EV_T1_OVF, 9, 15, "split high");
        // Counter source: only pin falls count
        tcase(8'h05, IDX_T0_LOW, 8'hfd, IDX_T0_HIGH, 8'hff, 8'h10, EV_T0_OVF, 1501, "idle");
        pin_u.pulse(PIN_C0, 3);
        pin_u.pulse(PIN_C0, 3);
        chk(int_request[EV_T0_OVF] === 1'b0, "counted clocks");
        pin_u.pulse(PIN_C0, 3);
        wait_ev(EV_T0_OVF, 0, 6, "counter overflow");
        // Gating holds the count while its pin is low
        pin_u.hold(PIN_X0, 1'b0);
        tcase(8'h09, IDX_T0_LOW, 8'hf0, IDX_T0_HIGH, 8'hff, 8'h10, EV_T0_OVF, 1501, "gate");
        pin_u.hold(PIN_X0, 1'b1);
        wait_ev(EV_T0_OVF, 30, 40, "gate release");
        // Both external inputs, level then edge
        for (int k = 0; k < 2; k++) begin
            wr(IDX_CONTROL_FLAGS, 8'h00);
            pin_u.hold(k, 1'b0);
            repeat (6) @(posedge pclk);
            chk(int_request[2 * k + 1] === 1'b1, "level low");
            pin_u.hold(k, 1'b1);
            repeat (6) @(posedge pclk);
            chk(int_request[2 * k + 1] === 1'b0, "level high");
            wr(IDX_CONTROL_FLAGS, 8'(1 << (2 * k)));
            pin_u.pulse(k, 4);
            chk(int_request[2 * k + 1] === 1'b1, "edge sticky");
            rd(IDX_CONTROL_FLAGS, 8'(3 << (2 * k)));
            wr(IDX_VECTOR_ACK, 8'(1 << (2 * k + 1)));
            @(posedge pclk);
            chk(int_request[2 * k + 1] === 1'b0, "edge ack");
        end
        stop_test();
    end
endmodule
